// file: common/sfc_pkg.sv
// Constants, enumerations and carrier types of the stream field joiner.
// Assumes a single clock domain and a SystemVerilog-2012 tool flow.
// How it works
// - In each joined lane, the upper-part sample fills the high bits and the lower-part sample the low bits.
// - Plain and plain-stream variants join combinationally, zero cycles delay.
// - Flow-controlled variant registers the path, at least two cycles.
// - Upper-part width is a parameter, 1 to 1024, default 8.
// - Lower-part width is a parameter, 1 to 1024, default 8.
// - Flow-controlled tuser width is a parameter, 1 to 8, default 1.
// - Supersample count is a parameter, 1 to 64, default 1.
// - Each bus carries that many samples, equal shares of its width.

package sfc_pkg;

    // ****************************************************************
    // Parameter ranges and defaults
    // ****************************************************************
    localparam int unsigned WIDTH_MIN = 1;
    localparam int unsigned WIDTH_MAX = 1024;
    localparam int unsigned WIDTH_DEF = 8;
    localparam int unsigned TUSER_MIN = 1;
    localparam int unsigned TUSER_MAX = 8;
    localparam int unsigned TUSER_DEF = 1;
    localparam int unsigned SS_MIN = 1;
    localparam int unsigned SS_MAX = 64;
    localparam int unsigned SS_DEF = 1;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int unsigned FC_LATENCY = 2;
    localparam int unsigned RST_SYNC_DEPTH = 2;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum {
        SFC_PLAIN,
        SFC_STREAM,
        SFC_STREAM_FC
    } sfc_variant_e;

    typedef struct packed {
        logic last;
        logic [TUSER_MAX-1:0] user;
    } sfc_side_s;

endpackage

// file: hw/sfc_join.sv
// Lane-by-lane joiner: pure wiring, no storage.
// Assumes both inputs carry the same supersample count.
`timescale 1ns/10ps

module sfc_join #(
    parameter int unsigned HW = sfc_pkg::WIDTH_DEF,
    parameter int unsigned LW = sfc_pkg::WIDTH_DEF,
    parameter int unsigned SS = sfc_pkg::SS_DEF
) (
    // Input words
    input logic [HW-1:0] i_upper,
    input logic [LW-1:0] i_lower,
    // Joined word
    output logic [HW+LW-1:0] o_joined
);

    localparam int unsigned UL = HW / SS;
    localparam int unsigned LL = LW / SS;
    localparam int unsigned JL = UL + LL;

    // ****************************************************************
    // One joined lane per sample
    // ****************************************************************
    for (genvar k = 0; k < SS; k++) begin : g_lane
        assign o_joined[k*JL +: JL] = {i_upper[k*UL +: UL],
                                       i_lower[k*LL +: LL]};
    end

endmodule

// file: hw/sfc_concat.sv
// Stream field joiner top: plain, plain-stream or flow-controlled variant.
// Assumes neighbours run on i_clk; only the reset is resynchronised.
`timescale 1ns/10ps

module sfc_concat #(
    parameter sfc_pkg::sfc_variant_e VARIANT = sfc_pkg::SFC_STREAM_FC,
    parameter int unsigned HW = sfc_pkg::WIDTH_DEF,
    parameter int unsigned LW = sfc_pkg::WIDTH_DEF,
    parameter int unsigned TW = sfc_pkg::TUSER_DEF,
    parameter int unsigned SS = sfc_pkg::SS_DEF
) (
    // Clock and reset
    input logic i_clk,
    input logic i_active_low_reset,
    // Upper-part input stream
    input logic [HW-1:0] i_up_tdata,
    input logic i_up_tvalid,
    input logic i_up_tlast,
    input logic [TW-1:0] i_up_tuser,
    output logic o_up_tready,
    // Lower-part input stream
    input logic [LW-1:0] i_lo_tdata,
    input logic i_lo_tvalid,
    input logic i_lo_tlast,
    input logic [TW-1:0] i_lo_tuser,
    output logic o_lo_tready,
    // Joined output stream
    output logic [HW+LW-1:0] o_tdata,
    output logic o_tvalid,
    output logic o_tlast,
    output logic [TW-1:0] o_tuser,
    input logic i_out_tready
);

    localparam int unsigned OW = HW + LW;
    localparam int unsigned UL = HW / SS;
    localparam int unsigned LL = LW / SS;

    // ****************************************************************
    // Elaboration checks
    // ****************************************************************
    if (HW < sfc_pkg::WIDTH_MIN || HW > sfc_pkg::WIDTH_MAX ||
        LW < sfc_pkg::WIDTH_MIN || LW > sfc_pkg::WIDTH_MAX) begin : g_bad_w
        $error("sfc_concat: data width out of range");
    end
    if (TW < sfc_pkg::TUSER_MIN || TW > sfc_pkg::TUSER_MAX) begin : g_bad_u
        $error("sfc_concat: tuser width out of range");
    end
    if (SS < sfc_pkg::SS_MIN || SS > sfc_pkg::SS_MAX ||
        (HW % SS) != 0 || (LW % SS) != 0) begin : g_bad_s
        $error("sfc_concat: supersample does not divide widths");
    end

    // ****************************************************************
    // Reset release
    // ****************************************************************
    logic [sfc_pkg::RST_SYNC_DEPTH-1:0] rst_sync_reg;
    wire rst_n = rst_sync_reg[sfc_pkg::RST_SYNC_DEPTH-1];

    always_ff @(posedge i_clk or negedge i_active_low_reset) begin
        if (!i_active_low_reset) begin
            rst_sync_reg <= '0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[sfc_pkg::RST_SYNC_DEPTH-2:0], 1'b1};
        end
    end

    // ****************************************************************
    // Joining
    // ****************************************************************
    wire [OW-1:0] joined;

    sfc_join #(
        .HW(HW),
        .LW(LW),
        .SS(SS)
    ) u_join (
        .i_upper(i_up_tdata),
        .i_lower(i_lo_tdata),
        .o_joined(joined)
    );

    function automatic logic [sfc_pkg::TUSER_MAX-1:0] widen_user(
        input logic [TW-1:0] u
    );
        widen_user = '0;
        widen_user[TW-1:0] = u;
    endfunction

    if (VARIANT == sfc_pkg::SFC_STREAM_FC) begin : g_fc

        // ************************************************************
        // Two-stage registered path
        // ************************************************************
        logic [OW-1:0] s1_data_reg, s2_data_reg;
        logic s1_valid_reg, s2_valid_reg;
        logic s1_valid_next, s2_valid_next;
        sfc_pkg::sfc_side_s s1_side_reg, s2_side_reg, in_side;

        wire s2_ready = !s2_valid_reg || i_out_tready;
        wire s1_ready = !s1_valid_reg || s2_ready;
        wire both_valid = i_up_tvalid && i_lo_tvalid;
        wire take = both_valid && s1_ready;
        wire advance = s1_valid_reg && s2_ready;

        // Ready on one side waits for the other side's valid
        assign o_up_tready = s1_ready && i_lo_tvalid;
        assign o_lo_tready = s1_ready && i_up_tvalid;

        // Sideband follows the upper-part stream
        assign in_side = '{last: i_up_tlast,
                           user: widen_user(i_up_tuser)};

        assign s1_valid_next = take || (s1_valid_reg && !s2_ready);
        assign s2_valid_next = advance || (s2_valid_reg && !i_out_tready);

        always_ff @(posedge i_clk or negedge rst_n) begin
            if (!rst_n) begin
                s1_valid_reg <= 1'b0;
                s2_valid_reg <= 1'b0;
            end else begin
                s1_valid_reg <= s1_valid_next;
                s2_valid_reg <= s2_valid_next;
            end
        end

        always_ff @(posedge i_clk or negedge rst_n) begin
            if (!rst_n) begin
                s1_data_reg <= '0;
                s1_side_reg <= '0;
            end else if (take) begin
                s1_data_reg <= joined;
                s1_side_reg <= in_side;
            end
        end

        always_ff @(posedge i_clk or negedge rst_n) begin
            if (!rst_n) begin
                s2_data_reg <= '0;
                s2_side_reg <= '0;
            end else if (advance) begin
                s2_data_reg <= s1_data_reg;
                s2_side_reg <= s1_side_reg;
            end
        end

        assign o_tdata = s2_data_reg;
        assign o_tvalid = s2_valid_reg;
        assign o_tlast = s2_side_reg.last;
        assign o_tuser = s2_side_reg.user[TW-1:0];

        // ************************************************************
        // Checks
        // ************************************************************
        sequence s_fill_empty;
            !s1_valid_reg && !s2_valid_reg && take;
        endsequence

        a_upper_msb: assert property (@(posedge i_clk) disable iff (!rst_n)
            take |=> s1_data_reg[OW-1 -: UL] == $past(i_up_tdata[HW-1 -: UL]))
            else $error("upper sample not in high bits");

        a_lower_lsb: assert property (@(posedge i_clk) disable iff (!rst_n)
            take |=> s1_data_reg[LL-1:0] == $past(i_lo_tdata[LL-1:0]))
            else $error("lower lane zero not in low bits");

        a_lane_pair: assert property (
            @(posedge i_clk) disable iff (!rst_n)
            take |=> s1_data_reg[UL+LL-1 -: UL] == $past(i_up_tdata[UL-1:0]))
            else $error("upper lane zero not beside lower lane zero");

        a_min_latency: assert property (@(posedge i_clk) disable iff (!rst_n)
            s_fill_empty |=> !o_tvalid ##1 o_tvalid)
            else $error("latency through empty path is not two cycles");

        a_side_pass: assert property (@(posedge i_clk) disable iff (!rst_n)
            s_fill_empty ##2 1'b1 |-> o_tlast == $past(i_up_tlast, 2) &&
                o_tuser == $past(i_up_tuser, 2))
            else $error("sideband not carried to output");

        a_accept_both: assert property (@(posedge i_clk) disable iff (!rst_n)
            (o_up_tready && i_up_tvalid) == (o_lo_tready && i_lo_tvalid))
            else $error("inputs accepted separately");

        a_no_lone_take: assert property (@(posedge i_clk) disable iff (!rst_n)
            !both_valid |-> !(o_up_tready && i_up_tvalid))
            else $error("input taken without partner");

        a_backpressure: assert property (@(posedge i_clk) disable iff (!rst_n)
            s1_valid_reg && o_tvalid && !i_out_tready |-> !o_up_tready &&
                !o_lo_tready)
            else $error("full path still ready");

        a_hold_stall: assert property (@(posedge i_clk) disable iff (!rst_n)
            o_tvalid && !i_out_tready |=> o_tvalid && $stable(o_tdata) &&
                $stable(o_tlast))
            else $error("output changed while stalled");

        a_drain_flow: assert property (@(posedge i_clk) disable iff (!rst_n)
            o_tvalid && i_out_tready && !s1_valid_reg |=> !o_tvalid)
            else $error("output valid without data behind it");

    end else begin : g_direct

        // ************************************************************
        // Zero-delay path; upstream keeps both valids aligned
        // ************************************************************
        assign o_tdata = joined;
        assign o_tvalid = i_up_tvalid;
        assign o_tlast = i_up_tlast;
        assign o_tuser = i_up_tuser;
        assign o_up_tready = i_out_tready;
        assign o_lo_tready = i_out_tready;

        a_zero_delay: assert property (@(posedge i_clk) disable iff (!rst_n)
            o_tdata[OW-1 -: UL] == i_up_tdata[HW-1 -: UL] &&
                o_tdata[LL-1:0] == i_lo_tdata[LL-1:0] &&
                o_tvalid == i_up_tvalid)
            else $error("direct path not immediate");

        a_direct_ready: assert property (
            @(posedge i_clk) disable iff (!rst_n)
            o_up_tready == i_out_tready && o_lo_tready == i_out_tready)
            else $error("direct readies not passed through");

    end

endmodule

// file: sim/sfc_sink.sv
// Downstream partner: takes the joined stream and can stall it on command.
// Assumes one clock; tready changes only at the falling edge.
`timescale 1ns/10ps

module sfc_sink #(
    parameter int unsigned DW = 16,
    parameter int unsigned TW = 2
) (
    // Clock and stall control
    input wire logic i_clk,
    input wire logic i_stall,
    // Joined stream
    input wire logic [DW-1:0] i_tdata,
    input wire logic i_tvalid,
    input wire logic i_tlast,
    input wire logic [TW-1:0] i_tuser,
    output logic o_tready
);
    // Accepted beats as {last, user, data}, oldest first
    logic [DW+TW:0] got[$];

    // Follows the stall control, which the bench moves at the falling edge
    assign o_tready = !i_stall;

    always @(posedge i_clk) begin
        if (i_tvalid === 1'b1 && o_tready === 1'b1) begin
            got.push_back({i_tlast, i_tuser, i_tdata});
        end
    end
endmodule

// file: sim/test_sfc_concat.sv
// Self-checking bench: flow-controlled joiner plus a plain-stream twin.
// Assumes sfc_pkg is compiled first; two lanes of four bits per input.
`timescale 1ns/10ps

module test_sfc_concat;
    localparam int unsigned W = 8;
    localparam int unsigned SS = 2;
    localparam int unsigned L = W / SS;
    logic i_clk, i_active_low_reset, up_v, lo_v, up_l, lo_l, stall, up_r, lo_r, rdy;
    logic o_v, o_l, d_v, d_l, r_ul, r_lr;
    logic [W-1:0] up_d, lo_d;
    logic [1:0] up_u, lo_u, o_u, d_u;
    logic [2*W-1:0] o_d, d_d;
    int num_errors, compares;

    sfc_concat #(.VARIANT(sfc_pkg::SFC_STREAM_FC), .HW(W), .LW(W), .TW(2),
        .SS(SS)) dut_u (.i_clk(i_clk), .i_active_low_reset(i_active_low_reset), .i_up_tdata(up_d),
        .i_up_tvalid(up_v), .i_up_tlast(up_l), .i_up_tuser(up_u),
        .o_up_tready(up_r), .i_lo_tdata(lo_d), .i_lo_tvalid(lo_v),
        .i_lo_tlast(lo_l), .i_lo_tuser(lo_u), .o_lo_tready(lo_r),
        .o_tdata(o_d), .o_tvalid(o_v), .o_tlast(o_l), .o_tuser(o_u),
        .i_out_tready(rdy));
    sfc_concat #(.VARIANT(sfc_pkg::SFC_STREAM), .HW(W), .LW(W), .TW(2),
        .SS(SS)) dut_d (.i_clk(i_clk), .i_active_low_reset(i_active_low_reset), .i_up_tdata(up_d),
        .i_up_tvalid(up_v), .i_up_tlast(up_l), .i_up_tuser(up_u),
        .o_up_tready(r_ul), .i_lo_tdata(lo_d), .i_lo_tvalid(lo_v),
        .i_lo_tlast(lo_l), .i_lo_tuser(lo_u), .o_lo_tready(r_lr),
        .o_tdata(d_d), .o_tvalid(d_v), .o_tlast(d_l), .o_tuser(d_u),
        .i_out_tready(rdy));
    sfc_sink #(.DW(2*W), .TW(2)) u_sink (.i_clk(i_clk), .i_stall(stall),
        .i_tdata(o_d), .i_tvalid(o_v), .i_tlast(o_l), .i_tuser(o_u),
        .o_tready(rdy));

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [2*W-1:0] jw(input logic [W-1:0] a, b);
        logic [2*W-1:0] r;
        for (int k = 0; k < SS; k++) begin
            r[k*2*L +: 2*L] = {a[k*L +: L], b[k*L +: L]};
        end
        return r;
    endfunction

    task automatic check(input logic [31:0] seen, exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        $display("compares %0d errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Presents one word pair and holds it until the take edge
    task automatic send(input logic [W-1:0] a, b, input logic l,
                        input logic [1:0] u);
        int n;
        @(negedge i_clk);
        up_v = 1'b1;
        lo_v = 1'b1;
        up_d = a;
        lo_d = b;
        up_l = l;
        up_u = u;
        lo_l = ~l;
        lo_u = ~u;
        #1;
        check({d_v, d_l, d_u, d_d}, {1'b1, l, u, jw(a, b)});
        n = 0;
        while (!(up_r === 1'b1 && lo_r === 1'b1) && n < 20) begin
            n++;
            @(negedge i_clk);
            #1;
        end
        check(n < 20, 1);
        @(posedge i_clk);
    endtask

    task automatic idle();
        @(negedge i_clk);
        up_v = 1'b0;
        lo_v = 1'b0;
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_lat();
        send(8'h3c, 8'h96, 1'b1, 2'h2);
        idle();
        check(o_v, 0);
        check({r_ul, r_lr}, 2'b11);
        @(negedge i_clk);
        check({o_v, o_l, o_u, o_d}, {1'b1, 1'b1, 2'h2, jw(8'h3c, 8'h96)});
        check(o_d, 16'h39c6);
        @(negedge i_clk);
        check(o_v, 0);
        $display("t_lat done");
    endtask

    task automatic t_alone();
        @(negedge i_clk);
        up_v = 1'b1;
        #1;
        check(up_r, 0);
        repeat (4) @(negedge i_clk);
        up_v = 1'b0;
        lo_v = 1'b1;
        #1;
        check({lo_r, o_v}, 0);
        repeat (4) @(negedge i_clk);
        check(o_v, 0);
        lo_v = 1'b0;
        $display("t_alone done");
    endtask

    task automatic t_stall();
        stall = 1'b1;
        u_sink.got.delete();
        send(8'h12, 8'h34, 1'b0, 2'h1);
        send(8'h56, 8'h78, 1'b1, 2'h2);
        @(negedge i_clk);
        up_d = 8'h9a;
        repeat (3) begin
            #1;
            check({up_r, lo_r, o_v, o_d}, {3'b001, jw(8'h12, 8'h34)});
            check({r_ul, r_lr}, 2'b00);
            @(negedge i_clk);
        end
        up_v = 1'b0;
        lo_v = 1'b0;
        stall = 1'b0;
        send(8'h9a, 8'hbc, 1'b0, 2'h3);
        idle();
        repeat (6) @(negedge i_clk);
        check(u_sink.got.size(), 3);
        check(u_sink.got[0], {3'h1, jw(8'h12, 8'h34)});
        check(u_sink.got[1], {3'h6, jw(8'h56, 8'h78)});
        check(u_sink.got[2], {3'h3, jw(8'h9a, 8'hbc)});
        $display("t_stall done");
    endtask

    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end

    initial begin
        #50000;
        num_errors++;
        close_out();
    end

    initial begin
        {i_active_low_reset, up_v, lo_v, up_l, lo_l, stall} = '0;
        {up_d, lo_d, up_u, lo_u} = '0;
        num_errors = 0;
        compares = 0;
        repeat (6) @(negedge i_clk);
        i_active_low_reset = 1'b1;
        repeat (3) @(negedge i_clk);
        check({o_v, o_d}, 0);
        t_lat();
        t_alone();
        t_stall();
        close_out();
    end
endmodule
